// file: rtl/acc_regs.svh
// Register offsets, field positions, reset values and timing counts for conversion control
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

`define ACC_ADDR_W 4
`define ACC_OFF_CTRL 4'h0
`define ACC_OFF_STAT 4'h1
`define ACC_OFF_IEN 4'h2
`define ACC_OFF_ICLR 4'h3

`define ACC_BIT_EN 7
`define ACC_BIT_TM 6
`define ACC_BIT_DONE 5
`define ACC_BIT_BUSY 4
`define ACC_BIT_SRC_HI 3
`define ACC_BIT_SRC_LO 2

`define ACC_IRQ_DONE 0
`define ACC_IRQ_OVRUN 1

`define ACC_CTRL_RST 8'h00
`define ACC_IEN_RST 8'h00
`define ACC_CONV_CYC 16'h0010

`endif

// file: rtl/acc_pkg.sv
// Types for the converter conversion control block
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_SRC_SW = 2'h0,
    ACC_SRC_TMR = 2'h1,
    ACC_SRC_EXT = 2'h2,
    ACC_SRC_RSV = 2'h3
  } acc_src_t;

  typedef enum logic [1:0] {
    ACC_ST_OFF = 2'h0,
    ACC_ST_TRACK = 2'h1,
    ACC_ST_CONV = 2'h3,
    ACC_ST_HOLD = 2'h2
  } acc_state_t;
endpackage

// file: rtl/acc_sync.sv
// Two-flop synchroniser with rising-edge detect on the synchronised level
`timescale 1ns/1ps
module acc_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic din,
  output logic rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
  } acc_sync_st_t;

  acc_sync_st_t st_r;
  acc_sync_st_t st_nxt;

  // Next state: only s2 looks at s1
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.rise = st_r.s2 & ~st_r.s3;
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rise = st_r.rise;
endmodule

// file: rtl/acc_top.sv
// Conversion control: control register, trigger selection, busy and done flags
// Functional notes
// - Enable low holds converter in shutdown
// - Track mode 0 tracks continuously when idle
// - Done flag shows a finished conversion
// - Done flag cleared only by software writing 0
// - Busy reads 1 during a conversion
// - Done flag sets on busy falling edge; an enable-low abort clears busy and leaves done unchanged
// - Busy write 1 starts only in mode 00
// - Mode 00 software, mode 01 timer overflow
// - Mode 10 synchronised external rising edge
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "acc_regs.svh"
module acc_top #(
  parameter logic [15:0] CONV_CYCLES = `ACC_CONV_CYC
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic [`ACC_ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic TIMER_OVF,
  input wire logic EXT_CONVERT_START,
  input wire logic CORE_DONE,
  output logic CONV_POWER_ON,
  output logic CONV_TRACK,
  output logic CONV_START,
  output logic CONV_BUSY,
  output logic IRQ
);
  import acc_pkg::*;

  typedef struct packed {
    logic en;
    logic tm;
    logic done;
    logic busy;
    acc_src_t src;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [15:0] cnt;
    acc_state_t st;
    logic [7:0] rdata;
    logic power;
    logic track;
    logic start;
    logic irq;
    logic tmr_d;
  } acc_st_t;

  acc_st_t st_r;
  acc_st_t st_nxt;
  logic ext_rise;

  // Field packing into the control register image
  function automatic logic [7:0] ctrl_image(input acc_st_t s);
    logic [7:0] v;
    v = 8'h00;
    v[`ACC_BIT_EN] = s.en;
    v[`ACC_BIT_TM] = s.tm;
    v[`ACC_BIT_DONE] = s.done;
    v[`ACC_BIT_BUSY] = s.busy;
    v[`ACC_BIT_SRC_HI:`ACC_BIT_SRC_LO] = s.src;
    return v;
  endfunction

  // External trigger synchroniser and edge detector
  acc_sync u_ext_sync (
    .clk(MCLK),
    .rst_b(RST_B),
    .din(EXT_CONVERT_START),
    .rise(ext_rise)
  );

  // Next-state logic
  always_comb begin
    logic trig;
    logic sw_go;
    logic wr_ctrl;
    logic finish;
    logic [1:0] ev;
    trig = 1'b0;
    sw_go = 1'b0;
    wr_ctrl = WR && (ADDR == `ACC_OFF_CTRL);
    finish = 1'b0;
    ev = 2'h0;
    st_nxt = st_r;
    st_nxt.start = 1'b0;
    st_nxt.tmr_d = TIMER_OVF;

    // Software write to the control register
    if (wr_ctrl) begin
      st_nxt.en = WDATA[`ACC_BIT_EN];
      st_nxt.tm = WDATA[`ACC_BIT_TM];
      st_nxt.src = acc_src_t'(WDATA[`ACC_BIT_SRC_HI:`ACC_BIT_SRC_LO]);
      if (!WDATA[`ACC_BIT_DONE]) begin
        st_nxt.done = 1'b0;
      end
      sw_go = WDATA[`ACC_BIT_BUSY] && (st_r.src == ACC_SRC_SW);
    end

    // Trigger source selection
    case (st_r.src)
      ACC_SRC_SW: trig = sw_go;
      ACC_SRC_TMR: trig = TIMER_OVF && !st_r.tmr_d;
      ACC_SRC_EXT: trig = ext_rise;
      ACC_SRC_RSV: trig = 1'b0;
      default: trig = 1'b0;
    endcase

    // Conversion sequencing
    case (st_r.st)
      ACC_ST_OFF: begin
        if (st_r.en) begin
          st_nxt.st = ACC_ST_TRACK;
        end
      end
      ACC_ST_TRACK: begin
        // Enable written low this cycle wins over any trigger
        if (!st_nxt.en) begin
          st_nxt.st = ACC_ST_OFF;
        end else if (trig) begin
          st_nxt.st = ACC_ST_CONV;
          st_nxt.busy = 1'b1;
          st_nxt.start = 1'b1;
          st_nxt.cnt = CONV_CYCLES;
        end
      end
      ACC_ST_CONV: begin
        if (trig) begin
          ev[`ACC_IRQ_OVRUN] = 1'b1;
        end
        // Abort at once so busy never outlives the power bit
        if (!st_nxt.en) begin
          st_nxt.st = ACC_ST_OFF;
          st_nxt.busy = 1'b0;
        end else if (CORE_DONE || st_r.cnt <= 16'h0001) begin
          finish = 1'b1;
          st_nxt.st = ACC_ST_HOLD;
        end else begin
          st_nxt.cnt = st_r.cnt - 16'h0001;
        end
      end
      ACC_ST_HOLD: begin
        st_nxt.st = st_nxt.en ? ACC_ST_TRACK : ACC_ST_OFF;
      end
      default: st_nxt.st = ACC_ST_OFF;
    endcase

    // Busy falls and done sets in the same cycle; set beats clear
    if (finish) begin
      st_nxt.busy = 1'b0;
      st_nxt.done = 1'b1;
      ev[`ACC_IRQ_DONE] = 1'b1;
    end

    // Tracking control
    if (!st_nxt.en || st_nxt.busy) begin
      st_nxt.track = 1'b0;
    end else if (!st_nxt.tm) begin
      st_nxt.track = 1'b1;
    end else begin
      st_nxt.track = (st_nxt.src != ACC_SRC_RSV);
    end
    st_nxt.power = st_nxt.en;

    // Interrupt registers
    if (WR && ADDR == `ACC_OFF_IEN) begin
      st_nxt.irq_en = WDATA[1:0];
    end
    if (WR && ADDR == `ACC_OFF_ICLR) begin
      st_nxt.irq_stat = st_r.irq_stat & ~WDATA[1:0];
    end
    st_nxt.irq_stat = st_nxt.irq_stat | ev;
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_en);

    // Read data, valid in the cycle after the strobe
    st_nxt.rdata = 8'h00;
    if (RD) begin
      case (ADDR)
        `ACC_OFF_CTRL: st_nxt.rdata = ctrl_image(st_r);
        `ACC_OFF_STAT: st_nxt.rdata = {6'h00, st_r.irq_stat};
        `ACC_OFF_IEN: st_nxt.rdata = {6'h00, st_r.irq_en};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r <= '0;
      st_r.st <= ACC_ST_OFF;
      st_r.src <= ACC_SRC_SW;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RDATA = st_r.rdata;
  assign CONV_POWER_ON = st_r.power;
  assign CONV_TRACK = st_r.track;
  assign CONV_START = st_r.start;
  assign CONV_BUSY = st_r.busy;
  assign IRQ = st_r.irq;
endmodule

// file: test/acc_core_model.sv
// Converter core model answering each start with a done pulse
`timescale 1ns/1ps
module acc_core_model #(
  parameter int DLY = 2
) (
  input wire logic clk,
  input wire logic start,
  output logic done
);
  int cnt = 0;
  initial done = 1'b0;
  // Count down from a start, pulse done on the last count
  always @(posedge clk) begin
    cnt <= start ? DLY : (cnt > 0 ? cnt - 1 : 0);
    done <= (cnt == 1);
  end
endmodule

// file: test/acc_top_monitor.sv
// Port checker for conversion control
`timescale 1ns/1ps
`include "acc_regs.svh"
module acc_top_monitor (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic [`ACC_ADDR_W-1:0] ADDR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic CONV_POWER_ON,
  input wire logic CONV_TRACK,
  input wire logic CONV_START,
  input wire logic CONV_BUSY
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  off_idle_a: assert property (!CONV_POWER_ON |-> !CONV_TRACK && !CONV_BUSY)
    else $error("converter active while off");
  busy_notrk_a: assert property (CONV_BUSY |-> !CONV_TRACK)
    else $error("tracking during conversion");
  rd_busy_a: assert property (RD && ADDR == `ACC_OFF_CTRL |=> RDATA[4] == $past(CONV_BUSY))
    else $error("busy bit read wrong");
  rise_start_a: assert property ($rose(CONV_BUSY) |-> CONV_START)
    else $error("busy without start");
  busy_bound_a: assert property ($rose(CONV_BUSY) |-> ##[1:20] !CONV_BUSY)
    else $error("conversion never ends");
  start_idle_a: assert property (CONV_START |-> !$past(CONV_BUSY) && CONV_BUSY)
    else $error("start while busy");
  start_pulse_a: assert property (CONV_START |=> !CONV_START)
    else $error("start pulse too long");
  rd_idle_a: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data outside read");
endmodule
bind acc_top acc_top_monitor mon_u (.*);

// file: test/acc_top_tb.sv
// Self-checking bench for conversion control
`timescale 1ns/1ps
`include "acc_regs.svh"
module acc_top_tb;
  logic MCLK = 0, RST_B = 0, WR = 0, RD = 0, TIMER_OVF = 0, EXT_CONVERT_START = 0;
  logic [3:0] ADDR = 0;
  logic [7:0] WDATA = 0, RDATA, rv;
  logic CORE_DONE, CONV_POWER_ON, CONV_TRACK, CONV_START, CONV_BUSY, IRQ;
  int n_mismatch = 0, checks = 0, cyc = 0, n_start = 0, n0;
  typedef struct {logic [7:0] ctrl; logic [2:0] hit;} acc_row_t;
  acc_row_t rows [4] = '{'{8'hC0, 3'h1}, '{8'h84, 3'h2}, '{8'h88, 3'h4}, '{8'h8C, 3'h0}};
  acc_top #(.CONV_CYCLES(16'h0004)) dut_u (.*);
  acc_core_model core_u (.clk(MCLK), .start(CONV_START), .done(CORE_DONE));
  always #5 MCLK = ~MCLK;
  // Start counter and hang limit
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    n_start <= n_start + CONV_START;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= w;
    RD <= !w;
    @(posedge MCLK);
    WR <= 0;
    RD <= 0;
    #1 rv = RDATA;
  endtask
  task summarize();
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Every start source against every start mode
  initial begin
    repeat (20) @(posedge MCLK);
    RST_B <= 1;
    bus(1, `ACC_OFF_IEN, 8'h01);
    foreach (rows[i]) begin
      for (int s = 0; s < 3; s++) begin
        bus(1, `ACC_OFF_CTRL, rows[i].ctrl);
        n0 = n_start;
        if (s == 0) bus(1, `ACC_OFF_CTRL, rows[i].ctrl | 8'h10);
        @(posedge MCLK);
        TIMER_OVF <= (s == 1);
        EXT_CONVERT_START <= (s == 2);
        @(posedge MCLK);
        TIMER_OVF <= 0;
        EXT_CONVERT_START <= 0;
        repeat (12) @(posedge MCLK);
        chk(8'(n_start - n0), 8'(rows[i].hit[s]));
        chk(8'(IRQ), 8'(rows[i].hit[s]));
        bus(0, `ACC_OFF_CTRL, 0);
        chk(rv, rows[i].ctrl | {2'h0, rows[i].hit[s], 5'h0});
        bus(1, `ACC_OFF_ICLR, 8'h03);
        chk(8'(IRQ), 8'h00);
      end
    end
    // Done flag survives a write of 1, masked interrupt stays low
    bus(1, `ACC_OFF_IEN, 8'h00);
    bus(1, `ACC_OFF_CTRL, 8'h80);
    chk(8'(CONV_TRACK), 8'h01);
    bus(1, `ACC_OFF_CTRL, 8'h90);
    bus(0, `ACC_OFF_CTRL, 0);
    chk(rv, 8'h90);
    chk(8'(CONV_TRACK), 8'h00);
    repeat (12) @(posedge MCLK);
    bus(1, `ACC_OFF_CTRL, 8'hA0);
    bus(0, `ACC_OFF_CTRL, 0);
    chk(rv, 8'hA0);
    chk(8'(IRQ), 8'h00);
    // Back-to-back starts: second one refused with overrun
    n0 = n_start;
    bus(1, `ACC_OFF_CTRL, 8'h90);
    chk(8'(CONV_BUSY), 8'h01);
    bus(1, `ACC_OFF_CTRL, 8'h90);
    repeat (12) @(posedge MCLK);
    chk(8'(n_start - n0), 8'h01);
    bus(0, `ACC_OFF_STAT, 0);
    chk(rv, 8'h03);
    // Disabled converter ignores a busy write
    bus(1, `ACC_OFF_CTRL, 8'h10);
    n0 = n_start;
    bus(1, `ACC_OFF_CTRL, 8'h10);
    repeat (4) @(posedge MCLK);
    chk(8'(n_start - n0), 8'h00);
    chk(8'(CONV_POWER_ON), 8'h00);
    bus(0, 4'hF, 0);
    chk(rv, 8'h00);
    // Reset in mid-run restores control value
    bus(1, `ACC_OFF_CTRL, 8'hCC);
    chk(8'(CONV_TRACK), 8'h00);
    chk(8'(CONV_POWER_ON), 8'h01);
    bus(1, `ACC_OFF_CTRL, 8'hC4);
    chk(8'(CONV_TRACK), 8'h01);
    RST_B <= 0;
    repeat (3) @(posedge MCLK);
    RST_B <= 1;
    bus(0, `ACC_OFF_CTRL, 0);
    chk(rv, `ACC_CTRL_RST);
    chk(8'(CONV_POWER_ON), 8'h00);
    summarize();
  end
endmodule
